/* File: hdl/lcd_scan_pkg.sv */
// shared constants and carriers for the matrix panel scan driver
`default_nettype none
package lcd_scan_pkg;
   // clock and refresh timing
   localparam int CLK_HZ = 25_000_000;
   localparam int FRAME_HZ = 70;
   localparam int DUTY_ROWS = 32;
   // cycles per scan line, rounded down so the frame never runs slow
   localparam int LINE_CYC = CLK_HZ / (FRAME_HZ * DUTY_ROWS);
   // panel geometry
   localparam int PANEL_ROWS = 64;
   localparam int HALF_COLS = 240;
   localparam int SEG_COLS = 480;
   localparam int DRV_OUTS = 50;
   localparam int DRV_USED = 40;
   localparam int DRV_COUNT = SEG_COLS / DRV_USED;
   localparam int PAGES = PANEL_ROWS / 8;
   localparam int RAM_BYTES = PAGES * HALF_COLS;
   // register map, byte addresses
   localparam logic [7:0] ADR_HOST = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   // host port fields
   localparam int HP_WORD_LSB = 0;
   localparam int HP_SEL_BIT = 8;
   // status fields
   localparam int ST_ROW_LSB = 0;
   localparam int ST_POL_BIT = 5;
   localparam int ST_ON_BIT = 6;
   localparam int ST_PAGE_LSB = 8;
   localparam int ST_COL_LSB = 16;
   // command encodings, upper nibble or whole byte
   localparam logic [3:0] CMD_COL_LO = 4'h0;
   localparam logic [3:0] CMD_COL_HI = 4'h1;
   localparam logic [3:0] CMD_PAGE = 4'hb;
   localparam logic [7:0] CMD_OFF = 8'hae;
   localparam logic [7:0] CMD_ON = 8'haf;
   // reset values
   localparam logic RST_POLARITY = 1'b0;
   localparam logic RST_DISP_ON = 1'b0;
   // wishbone carriers
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_s;
endpackage
`default_nettype wire

/* File: hdl/matrix_lcd_scan_driver.sv */
// matrix panel scan driver: host port, display ram, row and column drive
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module matrix_lcd_scan_driver
   import lcd_scan_pkg::*;
#(
   // cycles per scan line; shorten in simulation
   parameter int LINE_CYCLES = LINE_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire wb_req_s wbReq,
   output wb_rsp_s wbRsp,
   output logic [DUTY_ROWS-1:0] rowMasterOut,
   output logic [DUTY_ROWS-1:0] rowSlaveOut,
   output logic [DRV_COUNT-1:0][DRV_OUTS-1:0] segOut,
   output logic frame_pulse,
   output logic polarity_alternate,
   output logic line_shift_clock,
   output logic phaseOne,
   output logic phaseTwo
);

   // complete state of the block
   // everything that remembers anything lives in this one struct, so a
   // single asynchronous reset clears it all together; the display ram and
   // its read register ramQ_ff are the exceptions, since clearing the ram would
   // need a sweep of its own and the host rewrites the screen after reset anyway
   // the two row vectors are kept apart although they always agree, so
   // that each half can later be given its own timing without new state
   typedef struct packed {
      logic ack;
      logic [31:0] rdData;
      logic [2:0] page;
      logic [7:0] column;
      logic dispOn;
      logic [15:0] lineCnt;
      logic [4:0] row;
      logic polarity;
      logic frame;
      logic lineClk;
      logic [1:0] phase;
      logic [8:0] fillIdx;
      logic [SEG_COLS-1:0] shadow;
      logic [SEG_COLS-1:0] colOut;
      logic [DUTY_ROWS-1:0] rowMaster;
      logic [DUTY_ROWS-1:0] rowSlave;
   } state_s;

   state_s cur_ff; // registered state
   state_s nxt_cur; // next state
   logic [7:0] ram [RAM_BYTES]; // display ram, one bit per dot
   logic [7:0] ramQ_ff; // registered ram read data
   logic [10:0] rdAddr; // fill read address
   logic [10:0] wrAddr; // host write address
   logic ramWr; // host data write strobe
   logic [7:0] hostWord; // byte on the host port
   logic hostData; // select line, high for data
   logic busHit; // bus access in progress
   logic [4:0] fillRow; // row being prefetched
   logic fillHalf; // lower half while prefetching
   logic [7:0] fillCol; // column within the half
   logic lineEnd; // last cycle of a scan line

   // byte address of a page and column
   // shared by the host write port and the scan read port, so both sides
   // agree on where a dot lives; pages four to seven hold the lower half
   // the product is cut to eleven bits on purpose, the highest address
   // used stays well below the top of that range
   function automatic logic [10:0] ramAddr(input logic [2:0] pg,
                                           input logic [7:0] col);
      ramAddr = 11'(pg * HALF_COLS) + 11'(col);
   endfunction

   // host port decode
   // the request comes from logic on the same clock, so it is read here
   // with no synchroniser in front of it
   // a write with the low byte lane disabled is acked but does nothing,
   // and without the second lane the word is treated as a command
   assign busHit = wbReq.cyc & wbReq.stb;
   assign hostWord = wbReq.dat[HP_WORD_LSB +: 8];
   assign hostData = wbReq.sel[1] & wbReq.dat[HP_SEL_BIT];
   // writes take effect on the edge where the master sees ack
   assign ramWr = busHit & wbReq.we & cur_ff.ack & wbReq.sel[0]
                  & (wbReq.adr == ADR_HOST) & hostData;
   assign wrAddr = ramAddr(cur_ff.page, cur_ff.column);

   // prefetch walks upper half then lower half of the next row
   // one column is fetched every fourth cycle, so a full row of both
   // halves needs a little over nineteen hundred cycles; a line that is
   // shorter than that leaves the tail of the row stale
   // the row number wraps through five bits, so after the last row the
   // fetch starts again at row zero on its own
   assign fillRow = cur_ff.row + 5'h01;
   assign fillHalf = (cur_ff.fillIdx >= 9'(HALF_COLS));
   assign fillCol = fillHalf ? 8'(cur_ff.fillIdx - 9'(HALF_COLS))
                             : cur_ff.fillIdx[7:0];
   // page and bit pick one dot
   assign rdAddr = ramAddr({fillHalf, fillRow[4:3]}, fillCol);
   assign lineEnd = (cur_ff.lineCnt == 16'(LINE_CYCLES - 1));

   // display ram: one write port for the host, one read port for scan
   // the read is registered so the array can map onto block memory
   // a host write to a byte that is being fetched in the same cycle
   // returns the old byte; the new one shows a frame later, which is
   // invisible to the eye
   always_ff @(posedge clk_sys) begin
      if (ramWr) begin
         ram[wrAddr] <= hostWord;
      end
      ramQ_ff <= ram[rdAddr];
   end

   // next state
   // starts from a copy of the present state, so every field that a
   // branch leaves alone simply holds its value
   // order matters below: the bus answer first, then host writes, then
   // the prefetch, and the line end last, because the line end reads
   // the shadow row that the prefetch may have just completed
   always_comb begin
      nxt_cur = cur_ff;
      // ack is a single cycle, dropped the cycle after
      nxt_cur.ack = busHit & ~cur_ff.ack;
      // read data captured as the ack is raised
      if (busHit & ~cur_ff.ack) begin
         case (wbReq.adr)
            ADR_HOST: begin
               nxt_cur.rdData = 32'h0;
               nxt_cur.rdData[HP_SEL_BIT] = 1'b1;
            end
            ADR_STATUS: begin
               nxt_cur.rdData = 32'h0;
               nxt_cur.rdData[ST_ROW_LSB +: 5] = cur_ff.row;
               nxt_cur.rdData[ST_POL_BIT] = cur_ff.polarity;
               nxt_cur.rdData[ST_ON_BIT] = cur_ff.dispOn;
               nxt_cur.rdData[ST_PAGE_LSB +: 3] = cur_ff.page;
               nxt_cur.rdData[ST_COL_LSB +: 8] = cur_ff.column;
            end
            // unmapped reads return zero
            default: begin
               nxt_cur.rdData = 32'h0;
            end
         endcase
      end

      // host writes on the ack edge
      if (busHit & wbReq.we & cur_ff.ack & wbReq.sel[0]
          & (wbReq.adr == ADR_HOST)) begin
         if (hostData) begin
            // column auto-increments and wraps inside the half width
            if (cur_ff.column == 8'(HALF_COLS - 1)) begin
               nxt_cur.column = 8'h00;
            end else begin
               nxt_cur.column = cur_ff.column + 8'h01;
            end
         end else begin
            case (hostWord[7:4])
               CMD_COL_LO: begin
                  nxt_cur.column[3:0] = hostWord[3:0];
               end
               CMD_COL_HI: begin
                  nxt_cur.column[7:4] = hostWord[3:0];
               end
               CMD_PAGE: begin
                  nxt_cur.page = hostWord[2:0];
               end
               // display on and off share a nibble
               default: begin
                  if (hostWord == CMD_ON) begin
                     nxt_cur.dispOn = 1'b1;
                  end else if (hostWord == CMD_OFF) begin
                     nxt_cur.dispOn = 1'b0;
                  end
               end
            endcase
            // an out-of-range column would alias the next page
            if (nxt_cur.column > 8'(HALF_COLS - 1)) begin
               nxt_cur.column = 8'(HALF_COLS - 1);
            end
         end
      end

      // phase clocks from a divider
      // the two phases are enables, never used as clocks, so the
      // whole block stays on the one system clock
      // the read address is set up at least three cycles before the capture
      nxt_cur.phase = cur_ff.phase + 2'h1;
      if (cur_ff.phase == 2'h2 && cur_ff.fillIdx < 9'(SEG_COLS)) begin
         nxt_cur.shadow[cur_ff.fillIdx] = ramQ_ff[fillRow[2:0]];
         nxt_cur.fillIdx = cur_ff.fillIdx + 9'h001;
      end

      // master line timing
      // the line count rounds down, so the frame runs a touch fast
      // rather than slow; flicker stays away at the cost of a few
      // thousandths of a hertz
      // everything that moves at a line boundary moves on this edge
      nxt_cur.lineCnt = lineEnd ? 16'h0000 : cur_ff.lineCnt + 16'h0001;
      nxt_cur.lineClk = lineEnd;
      if (lineEnd) begin
         nxt_cur.row = fillRow;
         nxt_cur.frame = (fillRow == 5'h00);
         if (fillRow == 5'h00) begin
            nxt_cur.polarity = ~cur_ff.polarity;
         end
         nxt_cur.rowMaster = {cur_ff.rowMaster[DUTY_ROWS-2:0],
                              (fillRow == 5'h00)};
         nxt_cur.rowSlave = {cur_ff.rowSlave[DUTY_ROWS-2:0],
                             (fillRow == 5'h00)};
         nxt_cur.colOut = (cur_ff.dispOn ? nxt_cur.shadow
                           : {SEG_COLS{1'b0}})
                          ^ {SEG_COLS{nxt_cur.polarity}};
         nxt_cur.fillIdx = 9'h000;
      end
   end

   // state register
   // reset assigns constants only; the first row is selected and the
   // frame marker is up, so the panel starts from a clean frame
   // release of reset is taken as it comes; the bench releases it with a
   // nonblocking assignment right on a rising clock edge
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= '0;
         cur_ff.polarity <= RST_POLARITY;
         cur_ff.dispOn <= RST_DISP_ON;
         cur_ff.rowMaster <= 32'h00000001;
         cur_ff.rowSlave <= 32'h00000001;
         cur_ff.frame <= 1'b1;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // bus answer
   // both come straight from flip-flops, so the master sees no
   // combinational path from its request back to its own inputs
   assign wbRsp.ack = cur_ff.ack;
   assign wbRsp.dat = cur_ff.rdData;

   assign rowMasterOut = cur_ff.rowMaster;
   assign rowSlaveOut = cur_ff.rowSlave;
   assign frame_pulse = cur_ff.frame;
   assign polarity_alternate = cur_ff.polarity;
   assign line_shift_clock = cur_ff.lineClk;
   assign phaseOne = (cur_ff.phase == 2'h0);
   assign phaseTwo = (cur_ff.phase == 2'h2);

   // column outputs, forty used per driver
   // twelve drivers of forty used outputs cover all four hundred and
   // eighty columns; the spare ten of each driver are tied low so a
   // stray connection on the panel never sees a drive waveform
   // upper half columns come first, lower half columns follow
   genvar gd;
   generate
      for (gd = 0; gd < DRV_COUNT; gd++) begin : g_drv
         assign segOut[gd][DRV_USED-1:0] =
            cur_ff.colOut[gd*DRV_USED +: DRV_USED];
         assign segOut[gd][DRV_OUTS-1:DRV_USED] = '0;
      end
   endgenerate
   // 64 by 240 dots: 32 rows per half, 240 columns per half on 480 outputs

endmodule // matrix_lcd_scan_driver
`default_nettype wire

/* File: tb/lcd_scan_props.sv */
// port assertions for the matrix panel scan driver
`timescale 1ns/10ps
`default_nettype none
module lcd_scan_props
   import lcd_scan_pkg::*;
#(
   parameter int LINE_CYCLES = LINE_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire wb_req_s wbReq,
   input wire wb_rsp_s wbRsp,
   input wire logic [DUTY_ROWS-1:0] rowMasterOut,
   input wire logic [DUTY_ROWS-1:0] rowSlaveOut,
   input wire logic [DRV_COUNT-1:0][DRV_OUTS-1:0] segOut,
   input wire logic frame_pulse,
   input wire logic polarity_alternate,
   input wire logic line_shift_clock,
   input wire logic phaseOne,
   input wire logic phaseTwo
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [15:0] lineCnt_ff; // cycles since last line step
   logic seen_ff; // first step has no previous one to measure
   logic [9:0] unusedOr; // any unused column driven this cycle
   // line length counter
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lineCnt_ff <= 16'h0;
         seen_ff <= 1'b0;
      end else begin
         lineCnt_ff <= line_shift_clock ? 16'h0 : lineCnt_ff + 16'h1;
         seen_ff <= seen_ff | line_shift_clock;
      end
   end
   // fold the spare outputs of every driver
   always_comb begin
      unusedOr = '0;
      for (int i = 0; i < DRV_COUNT; i++) begin
         unusedOr = unusedOr | segOut[i][DRV_OUTS-1:DRV_USED];
      end
   end
   chk_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack
      |=> wbRsp.ack) else $error("ack late");
   chk_ack_pulse: assert property (wbRsp.ack |=> !wbRsp.ack)
      else $error("ack held");
   chk_ack_cause: assert property ($rose(wbRsp.ack) |-> $past(wbReq.stb))
      else $error("ack without request");
   chk_halves_sync: assert property (rowMasterOut == rowSlaveOut)
      else $error("slave off master");
   chk_row_onehot: assert property ($onehot(rowMasterOut))
      else $error("row not one-hot");
   chk_row_step: assert property ($changed(rowMasterOut) |->
      rowMasterOut == {$past(rowMasterOut[DUTY_ROWS-2:0]),
      $past(rowMasterOut[DUTY_ROWS-1])}) else $error("row skipped");
   chk_line_len: assert property (line_shift_clock && seen_ff |->
      lineCnt_ff == LINE_CYCLES - 1) else $error("line length");
   chk_frame_row: assert property (frame_pulse == rowMasterOut[0])
      else $error("frame off row 0");
   chk_pol_frame: assert property ($changed(polarity_alternate)
      |-> $rose(frame_pulse)) else $error("polarity mid frame");
   chk_phase_gap: assert property (phaseOne |-> !phaseTwo ##2 phaseTwo)
      else $error("phase spacing");
   chk_spare_low: assert property (unusedOr == '0)
      else $error("spare column driven");
endmodule // lcd_scan_props
bind matrix_lcd_scan_driver lcd_scan_props #(.LINE_CYCLES(LINE_CYCLES))
   lcd_scan_props_i (.clk_sys(clk_sys), .nrst(nrst), .wbReq(wbReq),
   .wbRsp(wbRsp), .rowMasterOut(rowMasterOut), .rowSlaveOut(rowSlaveOut),
   .segOut(segOut), .frame_pulse(frame_pulse),
   .polarity_alternate(polarity_alternate),
   .line_shift_clock(line_shift_clock), .phaseOne(phaseOne),
   .phaseTwo(phaseTwo));
`default_nettype wire

/* File: tb/lcd_host_model.sv */
// host processor model writing words over the register bus
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model
   import lcd_scan_pkg::*;
(
   input wire logic clk_sys,
   output var wb_req_s wbReq,
   input wire wb_rsp_s wbRsp
);
   // bus idle until a transfer is asked for
   initial wbReq = '0;
   // one classic cycle, held until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, output logic [31:0] rdat);
      @(posedge clk_sys);
      wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
      do @(posedge clk_sys); while (wbRsp.ack !== 1'b1);
      rdat = wbRsp.dat;
      wbReq <= '0;
   endtask
   task automatic put(input logic isData, input logic [7:0] w);
      logic [31:0] unused;
      xfer(1'b1, ADR_HOST, {23'h0, isData, w}, unused);
   endtask
endmodule // lcd_host_model
`default_nettype wire

/* File: tb/matrix_lcd_scan_driver_tb.sv */
// self-checking bench for the matrix panel scan driver
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module matrix_lcd_scan_driver_tb import lcd_scan_pkg::*;;
   localparam int LC = 2000; // short line, still covers the prefetch
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   wb_req_s wbReq;
   wb_rsp_s wbRsp;
   logic [DUTY_ROWS-1:0] rowMasterOut;
   logic [DUTY_ROWS-1:0] rowSlaveOut;
   logic [DRV_COUNT-1:0][DRV_OUTS-1:0] segOut;
   logic frame_pulse, polarity_alternate, line_shift_clock;
   logic phaseOne, phaseTwo;
   int num_errors = 0;
   int total_checks = 0;
   int cyc;
   logic [31:0] q;
   logic pol;
   always #20 clk_sys = ~clk_sys;
   matrix_lcd_scan_driver #(.LINE_CYCLES(LC)) matrix_lcd_scan_driver_i (
      .clk_sys(clk_sys), .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp),
      .rowMasterOut(rowMasterOut), .rowSlaveOut(rowSlaveOut),
      .segOut(segOut), .frame_pulse(frame_pulse),
      .polarity_alternate(polarity_alternate),
      .line_shift_clock(line_shift_clock), .phaseOne(phaseOne),
      .phaseTwo(phaseTwo));
   lcd_host_model lcd_host_model_i (.clk_sys(clk_sys), .wbReq(wbReq),
      .wbRsp(wbRsp));
   task automatic rd(input logic [7:0] a);
      lcd_host_model_i.xfer(1'b0, a, 32'h0, q);
   endtask
   // wait for a row, then let its column values settle
   task automatic waitRow(input int r);
      cyc = 0;
      while (rowMasterOut[r] !== 1'b1) begin
         @(posedge clk_sys);
         cyc++;
      end
      repeat (10) @(posedge clk_sys);
   endtask
   task automatic t_reset;
      `CHK(rowMasterOut, 32'h1)
      `CHK(rowSlaveOut, 32'h1)
      `CHK(polarity_alternate, RST_POLARITY)
      `CHK(segOut, '0)
   endtask
   task automatic t_host;
      rd(ADR_HOST);
      `CHK(q, 32'h100)
      rd(8'h08); // unmapped place reads zero
      `CHK(q, 32'h0)
      lcd_host_model_i.put(1'b0, {CMD_PAGE, 4'h3});
      lcd_host_model_i.put(1'b0, {CMD_COL_HI, 4'he});
      lcd_host_model_i.put(1'b0, {CMD_COL_LO, 4'hf});
      lcd_host_model_i.put(1'b0, CMD_ON);
      rd(ADR_STATUS);
      `CHK(q, 32'h00ef0340)
      lcd_host_model_i.put(1'b1, 8'h5a); // last column, wraps to 0
      rd(ADR_STATUS);
      `CHK(q, 32'h00000340)
   endtask
   task automatic t_scan;
      lcd_host_model_i.put(1'b0, {CMD_PAGE, 4'h0});
      lcd_host_model_i.put(1'b0, {CMD_COL_LO, 4'h5});
      lcd_host_model_i.put(1'b1, 8'h81);
      lcd_host_model_i.put(1'b0, {CMD_PAGE, 4'h4});
      lcd_host_model_i.put(1'b0, {CMD_COL_LO, 4'h5});
      lcd_host_model_i.put(1'b1, 8'h01);
      waitRow(7);
      pol = polarity_alternate;
      `CHK(segOut[0][5], ~pol)
      `CHK(segOut[6][5], pol)
      waitRow(24);
      `CHK(segOut[5][39], pol)
      waitRow(25);
      `CHK(segOut[5][39], ~pol)
      waitRow(0);
      `CHK(cyc, 7 * LC - 10)
      `CHK(polarity_alternate, ~pol)
      `CHK(segOut[0][5], pol)
      `CHK(segOut[6][5], pol)
      waitRow(1);
      `CHK(segOut[0][5], ~pol)
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      t_host();
      t_scan();
      end_sim();
   end
   // watchdog, about seven lines beyond the longest scenario
   initial begin
      repeat (80000) @(posedge clk_sys);
      num_errors++;
      end_sim();
   end
endmodule // matrix_lcd_scan_driver_tb
`default_nettype wire
